// >>> common/dltc_pkg.sv
// package: register map, field positions and shared types of the timer pair
//------------------------------------------------------------------------
// Function
// - mode 0: high byte holds upper eight, low byte lower five bits
// - mode 1: count through all sixteen bits, same enables as mode 0
// - mode 2: low byte counts, wrap sets flag and reloads from high byte
// - hardware never alters the high-byte reload value in mode 2
// - split mode: timer A low byte uses timer A controls and pins
// - split mode: timer A high byte runs on timer B run, sets B flag
// - timer A split: timer B runs without pin clock or flag setting
// - timer A split: timer B runs in modes 0 to 2, stops in mode 3
// - mode field: 13-bit, 16-bit, 8-bit reload, split dual 8-bit
// - timer B mode 3 makes timer B inactive, count held
// - overflow flags set by hardware, cleared by software or vectoring
// - gate 1 counts only while run is set and interrupt pin high
// - counter select 1 counts falling edges on the count pin
// - clock select bits 4 and 3 pick system or prescaled clock
// - prescale: divide by 12, 4, 48, or external clock by 8
// - external clock by eight is synchronised to the system clock
// - interrupt flags set by pin, cleared by software or edge vectoring
// - type bit: 0 active-low level, 1 falling edge
// - level mode interrupt flag follows inverse of its pin
// - upper three clock control bits read zero, writes ignored
// - setting run never clears the count
//------------------------------------------------------------------------
package dltc_pkg;
    // register addresses
    localparam logic [7:0] ADDR_CTRL = 8'h88;
    localparam logic [7:0] ADDR_MODE = 8'h89;
    localparam logic [7:0] ADDR_A_LO = 8'h8A;
    localparam logic [7:0] ADDR_B_LO = 8'h8B;
    localparam logic [7:0] ADDR_A_HI = 8'h8C;
    localparam logic [7:0] ADDR_B_HI = 8'h8D;
    localparam logic [7:0] ADDR_CKC = 8'h8E;
    // reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_CNT = 8'h00;
    localparam logic [7:0] RST_CKC = 8'h00;
    // control register fields
    localparam int B_TF = 7;
    localparam int B_TR = 6;
    localparam int A_TF = 5;
    localparam int A_TR = 4;
    localparam int B_IE = 3;
    localparam int B_IT = 2;
    localparam int A_IE = 1;
    localparam int A_IT = 0;
    // clock control fields
    localparam int CK_B_SEL = 4;
    localparam int CK_A_SEL = 3;
    localparam logic [7:0] CKC_MASK = 8'h1F;
    // prescale divide counts
    localparam int DIV_12 = 12;
    localparam int DIV_4 = 4;
    localparam int DIV_48 = 48;
    localparam int DIV_EXT = 8;
    localparam int DIV_W = 6;
    // mode field encodings
    localparam logic [1:0] MODE_13 = 2'h0;
    localparam logic [1:0] MODE_16 = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT = 2'h3;

    // per-timer mode register nibble
    typedef struct packed {
        logic gate_ctrl;
        logic counter_select;
        logic [1:0] mode_field;
    } dltc_tmode_s;

    // register bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dltc_req_s;

    // result of one timer's count step
    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
        logic ovf;
    } dltc_step_s;
endpackage

// >>> hw/dltc_top.sv
// module: dual legacy counter/timer pair behind special function registers
`timescale 1ns/100ps
module dltc_top
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire dltc_pkg::dltc_req_s sfr_req,
    output logic [7:0] sfr_rdata,
    input wire logic timer_a_vector_ack,
    input wire logic timer_b_vector_ack,
    input wire logic ext_irq_a_vector_ack,
    input wire logic ext_irq_b_vector_ack,
    input wire logic ext_irq_a_pin,
    input wire logic ext_irq_b_pin,
    input wire logic timer_a_count_pin,
    input wire logic timer_b_count_pin,
    input wire logic ext_clk_pin,
    output logic timer_b_overflow_pulse,
    output logic [7:0] timer_control_q_o
);
    //--------------------------------------------------------------------
    // registers
    //--------------------------------------------------------------------
    logic [7:0] timer_control_q;
    dltc_pkg::dltc_tmode_s a_mode_q, b_mode_q;
    logic [4:0] timer_clock_control_q;
    logic [7:0] a_lo_q, a_hi_q, b_lo_q, b_hi_q;

    //--------------------------------------------------------------------
    // pin synchronisers, two flops each, then one history flop
    //--------------------------------------------------------------------
    logic [4:0] pin_s1_q, pin_s2_q, pin_s3_q;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_q <= 5'h1F;
            pin_s2_q <= 5'h1F;
            pin_s3_q <= 5'h1F;
        end
        else
        begin
            pin_s1_q <= {ext_clk_pin, timer_b_count_pin, timer_a_count_pin,
                         ext_irq_b_pin, ext_irq_a_pin};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end
    logic irq_a_lvl, irq_b_lvl, irq_a_fall, irq_b_fall;
    logic cnt_a_fall, cnt_b_fall, ext_rise;
    assign irq_a_lvl = pin_s2_q[0];
    assign irq_b_lvl = pin_s2_q[1];
    assign irq_a_fall = pin_s3_q[0] & ~pin_s2_q[0];
    assign irq_b_fall = pin_s3_q[1] & ~pin_s2_q[1];
    assign cnt_a_fall = pin_s3_q[2] & ~pin_s2_q[2];
    assign cnt_b_fall = pin_s3_q[3] & ~pin_s2_q[3];
    assign ext_rise = ~pin_s3_q[4] & pin_s2_q[4];

    //--------------------------------------------------------------------
    // prescaler: one-cycle tick per divided period
    //--------------------------------------------------------------------
    logic [dltc_pkg::DIV_W-1:0] div_cnt_q;
    logic [dltc_pkg::DIV_W-1:0] div_top;
    logic div_src, pre_tick;
    always_comb
    begin
        div_src = 1'b1;
        case (timer_clock_control_q[1:0])
            2'h0: div_top = dltc_pkg::DIV_W'(dltc_pkg::DIV_12 - 1);
            2'h1: div_top = dltc_pkg::DIV_W'(dltc_pkg::DIV_4 - 1);
            2'h2: div_top = dltc_pkg::DIV_W'(dltc_pkg::DIV_48 - 1);
            default:
            begin
                div_top = dltc_pkg::DIV_W'(dltc_pkg::DIV_EXT - 1);
                div_src = ext_rise;
            end
        endcase
    end
    assign pre_tick = div_src && (div_cnt_q >= div_top);
    // counter resets on wrap; a smaller top after a change still wraps
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            div_cnt_q <= '0;
        else if (pre_tick)
            div_cnt_q <= '0;
        else if (div_src)
            div_cnt_q <= div_cnt_q + 1'b1;
    end

    //--------------------------------------------------------------------
    // count enables
    //--------------------------------------------------------------------
    // gate uses the pin level itself, also in auto-reload
    function automatic logic run_ok(input logic run, input logic gate,
                                    input logic pin);
        return run && (!gate || pin);
    endfunction
    // timer clock event: pin edge, system clock or prescaler tick
    function automatic logic clk_ev(input logic csel, input logic ksel,
                                    input logic fall, input logic pre);
        return csel ? fall : (ksel ? 1'b1 : pre);
    endfunction

    logic a_split, a_ev, a_hi_ev, b_ev;
    assign a_split = (a_mode_q.mode_field == dltc_pkg::MODE_SPLIT);
    assign a_ev = run_ok(timer_control_q[dltc_pkg::A_TR],
        a_mode_q.gate_ctrl, irq_a_lvl)
        && clk_ev(a_mode_q.counter_select,
        timer_clock_control_q[dltc_pkg::CK_A_SEL], cnt_a_fall, pre_tick);
    // split high byte: timer clock only, run by timer B run bit
    assign a_hi_ev = timer_control_q[dltc_pkg::B_TR]
        && clk_ev(1'b0, timer_clock_control_q[dltc_pkg::CK_A_SEL],
        1'b0, pre_tick);
    // timer B under split A: no pin clock, run from mode field only
    always_comb
    begin
        if (b_mode_q.mode_field == dltc_pkg::MODE_SPLIT)
            b_ev = 1'b0;
        else if (a_split)
            b_ev = clk_ev(1'b0, timer_clock_control_q[dltc_pkg::CK_B_SEL],
                1'b0, pre_tick);
        else
            b_ev = run_ok(timer_control_q[dltc_pkg::B_TR],
                b_mode_q.gate_ctrl, irq_b_lvl)
                && clk_ev(b_mode_q.counter_select,
                timer_clock_control_q[dltc_pkg::CK_B_SEL],
                cnt_b_fall, pre_tick);
    end

    //--------------------------------------------------------------------
    // count step shared by both timers
    //--------------------------------------------------------------------
    function automatic dltc_pkg::dltc_step_s step(input logic [1:0] mode,
        input logic [7:0] lo, input logic [7:0] hi);
        dltc_pkg::dltc_step_s r;
        logic [16:0] w;
        r = '{lo: lo, hi: hi, ovf: 1'b0};
        w = '0;
        case (mode)
            dltc_pkg::MODE_13:
            begin
                w = {4'h0, hi, lo[4:0]} + 17'h00001;
                r.lo = {lo[7:5], w[4:0]};
                r.hi = w[12:5];
                r.ovf = w[13];
            end
            dltc_pkg::MODE_16:
            begin
                w = {1'b0, hi, lo} + 17'h00001;
                r.lo = w[7:0];
                r.hi = w[15:8];
                r.ovf = w[16];
            end
            dltc_pkg::MODE_RELOAD:
            begin
                r.ovf = (lo == 8'hFF);
                r.lo = r.ovf ? hi : lo + 8'h01;
            end
            default:
            begin
                r.ovf = (lo == 8'hFF);
                r.lo = lo + 8'h01;
            end
        endcase
        return r;
    endfunction

    dltc_pkg::dltc_step_s a_nx, b_nx;
    logic a_hi_ovf;
    assign a_nx = step(a_mode_q.mode_field, a_lo_q, a_hi_q);
    assign b_nx = step(b_mode_q.mode_field, b_lo_q, b_hi_q);
    assign a_hi_ovf = a_split && a_hi_ev && (a_hi_q == 8'hFF);

    //--------------------------------------------------------------------
    // count registers; writes win, counts resume from held value
    //--------------------------------------------------------------------
    logic wr;
    assign wr = sfr_req.wr;
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            a_lo_q <= dltc_pkg::RST_CNT;
            a_hi_q <= dltc_pkg::RST_CNT;
        end
        else
        begin
            if (wr && sfr_req.addr == dltc_pkg::ADDR_A_LO)
                a_lo_q <= sfr_req.wdata;
            else if (a_ev)
                a_lo_q <= a_nx.lo;
            if (wr && sfr_req.addr == dltc_pkg::ADDR_A_HI)
                a_hi_q <= sfr_req.wdata;
            else if (a_split && a_hi_ev)
                a_hi_q <= a_hi_q + 8'h01;
            else if (a_ev && !a_split)
                a_hi_q <= a_nx.hi;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            b_lo_q <= dltc_pkg::RST_CNT;
            b_hi_q <= dltc_pkg::RST_CNT;
        end
        else
        begin
            if (wr && sfr_req.addr == dltc_pkg::ADDR_B_LO)
                b_lo_q <= sfr_req.wdata;
            else if (b_ev)
                b_lo_q <= b_nx.lo;
            if (wr && sfr_req.addr == dltc_pkg::ADDR_B_HI)
                b_hi_q <= sfr_req.wdata;
            else if (b_ev)
                b_hi_q <= b_nx.hi;
        end
    end

    //--------------------------------------------------------------------
    // mode and clock control registers
    //--------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {b_mode_q, a_mode_q} <= dltc_pkg::RST_MODE;
            timer_clock_control_q <= dltc_pkg::RST_CKC[4:0];
        end
        else if (wr && sfr_req.addr == dltc_pkg::ADDR_MODE)
            {b_mode_q, a_mode_q} <= sfr_req.wdata;
        else if (wr && sfr_req.addr == dltc_pkg::ADDR_CKC)
            timer_clock_control_q <= sfr_req.wdata[4:0];
    end

    //--------------------------------------------------------------------
    // control register: flags set by hardware win over clears
    //--------------------------------------------------------------------
    logic a_tf_set, b_tf_set, a_ie_set, b_ie_set;
    logic ctrl_wr;
    logic [7:0] ctrl_d;
    assign ctrl_wr = wr && sfr_req.addr == dltc_pkg::ADDR_CTRL;
    assign a_tf_set = a_ev && a_nx.ovf;
    // timer B flag comes from split A high byte, never from B then
    assign b_tf_set = a_split ? a_hi_ovf : (b_ev && b_nx.ovf);
    // level mode tracks inverted pin; edge mode latches falling edge
    assign a_ie_set = timer_control_q[dltc_pkg::A_IT] ? irq_a_fall
        : !irq_a_lvl;
    assign b_ie_set = timer_control_q[dltc_pkg::B_IT] ? irq_b_fall
        : !irq_b_lvl;
    always_comb
    begin
        ctrl_d = ctrl_wr ? sfr_req.wdata : timer_control_q;
        if (timer_a_vector_ack)
            ctrl_d[dltc_pkg::A_TF] = 1'b0;
        if (timer_b_vector_ack)
            ctrl_d[dltc_pkg::B_TF] = 1'b0;
        if (ext_irq_a_vector_ack && timer_control_q[dltc_pkg::A_IT])
            ctrl_d[dltc_pkg::A_IE] = 1'b0;
        if (ext_irq_b_vector_ack && timer_control_q[dltc_pkg::B_IT])
            ctrl_d[dltc_pkg::B_IE] = 1'b0;
        // in level mode the flag simply mirrors the inverted pin
        if (!timer_control_q[dltc_pkg::A_IT])
            ctrl_d[dltc_pkg::A_IE] = a_ie_set;
        if (!timer_control_q[dltc_pkg::B_IT])
            ctrl_d[dltc_pkg::B_IE] = b_ie_set;
        if (a_tf_set)
            ctrl_d[dltc_pkg::A_TF] = 1'b1;
        if (b_tf_set)
            ctrl_d[dltc_pkg::B_TF] = 1'b1;
        if (a_ie_set)
            ctrl_d[dltc_pkg::A_IE] = 1'b1;
        if (b_ie_set)
            ctrl_d[dltc_pkg::B_IE] = 1'b1;
    end
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            timer_control_q <= dltc_pkg::RST_CTRL;
        else
            timer_control_q <= ctrl_d;
    end

    //--------------------------------------------------------------------
    // outputs: registered read data and overflow pulse
    //--------------------------------------------------------------------
    // timer B overflow still feeds baud/convert triggers when split
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            timer_b_overflow_pulse <= 1'b0;
        else
            timer_b_overflow_pulse <= b_ev && b_nx.ovf;
    end
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            sfr_rdata <= 8'h00;
        else if (sfr_req.rd)
        begin
            case (sfr_req.addr)
                dltc_pkg::ADDR_CTRL: sfr_rdata <= timer_control_q;
                dltc_pkg::ADDR_MODE: sfr_rdata <= {b_mode_q, a_mode_q};
                dltc_pkg::ADDR_A_LO: sfr_rdata <= a_lo_q;
                dltc_pkg::ADDR_B_LO: sfr_rdata <= b_lo_q;
                dltc_pkg::ADDR_A_HI: sfr_rdata <= a_hi_q;
                dltc_pkg::ADDR_B_HI: sfr_rdata <= b_hi_q;
                dltc_pkg::ADDR_CKC:
                    sfr_rdata <= {3'h0, timer_clock_control_q};
                default: sfr_rdata <= 8'h00;
            endcase
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            timer_control_q_o <= dltc_pkg::RST_CTRL;
        else
            timer_control_q_o <= ctrl_d;
    end
endmodule

// >>> verif/dltc_checker.sv
// checker: port-level assertions for the counter/timer pair
`timescale 1ns/100ps
module dltc_checker
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire dltc_pkg::dltc_req_s sfr_req,
    input wire logic [7:0] sfr_rdata,
    input wire logic timer_a_vector_ack,
    input wire logic timer_b_vector_ack,
    input wire logic ext_irq_a_vector_ack,
    input wire logic ext_irq_a_pin,
    input wire logic ext_irq_b_pin,
    input wire logic timer_b_overflow_pulse,
    input wire logic [7:0] timer_control_q_o
);
    //------------------------------------------------------------
    // helper state
    //------------------------------------------------------------
    logic ctrl_wr;
    logic [7:0] mode_q;
    logic [7:0] tc;
    assign ctrl_wr = sfr_req.wr && sfr_req.addr == dltc_pkg::ADDR_CTRL;
    assign tc = timer_control_q_o;
    // mode shadow: split operation moves ownership of the b flag
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            mode_q <= 8'h00;
        else if (sfr_req.wr && sfr_req.addr == dltc_pkg::ADDR_MODE)
            mode_q <= sfr_req.wdata;
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // pin long quiet, so no falling edge is still in the synchroniser
    sequence s_irq_a_quiet;
        ext_irq_a_pin [*6];
    endsequence
    sequence s_edge_ack;
        ext_irq_a_vector_ack && tc[0] && !ctrl_wr;
    endsequence
    a_run_bits_written: assert property (
        ctrl_wr |=> tc[6] == $past(sfr_req.wdata[6])
            && tc[4] == $past(sfr_req.wdata[4]))
        else $error("run bits differ from the written value");
    a_run_bits_held: assert property (
        !ctrl_wr |=> $stable({tc[6], tc[4]}))
        else $error("run bits changed without a write");
    a_ckc_upper_zero: assert property (
        sfr_req.rd && sfr_req.addr == dltc_pkg::ADDR_CKC
            |=> sfr_rdata[7:5] == 3'h0)
        else $error("clock control upper bits not zero");
    a_level_mirror_a: assert property (
        (!tc[0] && $stable(ext_irq_a_pin)) [*5] |-> tc[1] == !ext_irq_a_pin)
        else $error("level flag a does not mirror its pin");
    a_level_mirror_b: assert property (
        (!tc[2] && $stable(ext_irq_b_pin)) [*5] |-> tc[3] == !ext_irq_b_pin)
        else $error("level flag b does not mirror its pin");
    a_edge_ack_clears: assert property (
        s_irq_a_quiet ##0 s_edge_ack |=> !tc[1])
        else $error("edge flag a kept after vectoring");
    a_b_flag_follows: assert property (
        timer_b_overflow_pulse && mode_q[1:0] != dltc_pkg::MODE_SPLIT
            |-> ##[0:1] tc[7])
        else $error("b overflow did not set its flag");
    a_a_ack_clears: assert property (
        timer_a_vector_ack && !tc[4] && !ctrl_wr |=> !tc[5])
        else $error("a flag kept after vectoring");
    a_b_ack_clears: assert property (
        timer_b_vector_ack && !tc[6] && !ctrl_wr |=> !tc[7])
        else $error("b flag kept after vectoring");
endmodule

bind dltc_top dltc_checker u_chk
(
    .sys_clk,
    .rst_n,
    .sfr_req,
    .sfr_rdata,
    .timer_a_vector_ack,
    .timer_b_vector_ack,
    .ext_irq_a_vector_ack,
    .ext_irq_a_pin,
    .ext_irq_b_pin,
    .timer_b_overflow_pulse,
    .timer_control_q_o
);

// >>> verif/dltc_pin_model.sv
// partner: count, gate, interrupt and external clock pins
`timescale 1ns/100ps
module dltc_pin_model
(
    input wire logic sys_clk,
    input wire logic ext_clk_en,
    output logic ext_irq_a_pin,
    output logic ext_irq_b_pin,
    output logic timer_a_count_pin,
    output logic timer_b_count_pin,
    output logic ext_clk_pin
);
    //------------------------------------------------------------
    // pin drivers
    //------------------------------------------------------------
    // idle levels: pins high, clock still
    initial
    begin
        ext_irq_a_pin = 1'b1;
        ext_irq_b_pin = 1'b1;
        timer_a_count_pin = 1'b1;
        timer_b_count_pin = 1'b1;
        ext_clk_pin = 1'b0;
    end
    // 24 ns period, slower than the system clock; still when off
    always #12 ext_clk_pin = ext_clk_en ? ~ext_clk_pin : 1'b0;
    // one level, held three system clocks so sampling cannot miss it
    task automatic hold(input int which, input logic v);
        @(negedge sys_clk);
        case (which)
            0: timer_a_count_pin = v;
            1: timer_b_count_pin = v;
            2: ext_irq_a_pin = v;
            default: ext_irq_b_pin = v;
        endcase
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic count(input int which, input int n);
        repeat (n)
        begin
            hold(which, 1'b0);
            hold(which, 1'b1);
        end
    endtask
endmodule

// >>> verif/dltc_top_test.sv
// testbench: register-level scenarios for the counter/timer pair
`timescale 1ns/100ps
module dltc_top_test;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    dltc_pkg::dltc_req_s sfr_req = '0;
    logic [3:0] ack = 4'h0;
    logic ext_clk_en = 1'b0;
    logic saw_pulse = 1'b0;
    logic [7:0] sfr_rdata;
    logic [7:0] ctrl_q;
    logic ext_irq_a_pin, ext_irq_b_pin, ext_clk_pin, b_pulse;
    logic timer_a_count_pin, timer_b_count_pin;
    logic [7:0] ck [5] = '{8'h08, 8'h00, 8'h01, 8'h02, 8'h03};
    int per [5] = '{1, 12, 4, 48, 48};
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    dltc_top dut (.sys_clk, .rst_n, .sfr_req, .sfr_rdata,
        .timer_a_vector_ack(ack[0]), .timer_b_vector_ack(ack[1]),
        .ext_irq_a_vector_ack(ack[2]), .ext_irq_b_vector_ack(ack[3]),
        .ext_irq_a_pin, .ext_irq_b_pin, .timer_a_count_pin,
        .timer_b_count_pin, .ext_clk_pin,
        .timer_b_overflow_pulse(b_pulse), .timer_control_q_o(ctrl_q));
    dltc_pin_model pm (.sys_clk, .ext_clk_en, .ext_irq_a_pin,
        .ext_irq_b_pin, .timer_a_count_pin, .timer_b_count_pin,
        .ext_clk_pin);
    always #2 sys_clk = ~sys_clk;
    //------------------------------------------------------------
    // access tasks
    //------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        sfr_req = {1'b1, 1'b0, a, d};
        @(negedge sys_clk);
        sfr_req = '0;
    endtask
    // data read two falling edges on; it stands until the next read
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        sfr_req = {1'b0, 1'b1, a, 8'h00};
        @(negedge sys_clk);
        sfr_req = '0;
        @(negedge sys_clk);
        d = sfr_rdata;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp);
    endtask
    // prescaler phase is free, so a timed count may be one off
    task automatic chk_in(input logic [15:0] got, input int lo, input int hi);
        samples_checked++;
        if ((got >= lo && got <= hi) !== 1'b1)
        begin
            err_count++;
            $display("MISMATCH t=%0t count %h", $time, got);
        end
    endtask
    task automatic pulse(input int i);
        @(negedge sys_clk);
        ack[i] = 1'b1;
        @(negedge sys_clk);
        ack[i] = 1'b0;
    endtask
    task automatic close_out;
        $display("mismatches %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // sampled mid-cycle so the one-cycle pulse is seen while it stands
    always @(negedge sys_clk)
    begin
        cycles++;
        if (b_pulse === 1'b1)
            saw_pulse = 1'b1;
        if (cycles == 10000)
        begin
            err_count++;
            $display("MISMATCH t=%0t timeout", $time);
            close_out();
        end
    end
    //------------------------------------------------------------
    // scenarios
    //------------------------------------------------------------
    initial
    begin
        logic [7:0] rv;
        logic [7:0] hv;
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        for (int a = 'h88; a <= 'h8E; a++)
            rchk(8'(a), 8'h00);
        wr(8'h90, 8'hA5);
        rchk(8'h90, 8'h00);
        wr(8'h8E, 8'hFF);
        rchk(8'h8E, 8'h1F);
        // 16-bit counter on pin a, start value kept when run is set
        wr(8'h89, 8'h05);
        wr(8'h8A, 8'hFE);
        wr(8'h8C, 8'h12);
        wr(8'h88, 8'h10);
        pm.count(0, 3);
        wr(8'h88, 8'h00);
        rchk(8'h8A, 8'h01);
        rchk(8'h8C, 8'h13);
        // 13-bit wrap from all ones
        wr(8'h89, 8'h04);
        wr(8'h8A, 8'h1F);
        wr(8'h8C, 8'hFF);
        wr(8'h88, 8'h10);
        pm.count(0, 1);
        wr(8'h88, 8'h20);
        rchk(8'h8A, 8'h00);
        rchk(8'h8C, 8'h00);
        rchk(8'h88, 8'h20);
        pulse(0);
        rchk(8'h88, 8'h00);
        // auto-reload on b, low byte loaded before running
        wr(8'h89, 8'h60);
        wr(8'h8B, 8'hFE);
        wr(8'h8D, 8'hF0);
        saw_pulse = 1'b0;
        wr(8'h88, 8'h40);
        pm.count(1, 3);
        chk(ctrl_q, 8'hC0);
        wr(8'h88, 8'h00);
        rchk(8'h8B, 8'hF1);
        rchk(8'h8D, 8'hF0);
        chk({7'h00, saw_pulse}, 8'h01);
        rchk(8'h88, 8'h00);
        // gated reload: pin b low blocks counting, raises level flag
        wr(8'h89, 8'hE0);
        wr(8'h8B, 8'h10);
        pm.hold(3, 1'b0);
        wr(8'h88, 8'h40);
        pm.count(1, 2);
        chk(ctrl_q, 8'h48);
        pm.hold(3, 1'b1);
        pm.count(1, 2);
        wr(8'h88, 8'h00);
        rchk(8'h8B, 8'h12);
        rchk(8'h88, 8'h00);
        // timed counts for every clock source
        wr(8'h89, 8'h01);
        for (int i = 0; i < 5; i++)
        begin
            wr(8'h8E, ck[i]);
            wr(8'h8A, 8'h00);
            wr(8'h8C, 8'h00);
            ext_clk_en = (i == 4);
            wr(8'h88, 8'h10);
            repeat (478) @(negedge sys_clk);
            wr(8'h88, 8'h00);
            rd(8'h8A, rv);
            rd(8'h8C, hv);
            chk_in({hv, rv}, 480 / per[i] - 1, 480 / per[i] + 1);
        end
        ext_clk_en = 1'b0;
        // split: a high byte runs on b run and owns the b flag
        wr(8'h8E, 8'h18);
        wr(8'h89, 8'h33);
        wr(8'h8A, 8'h00);
        wr(8'h8C, 8'hF0);
        wr(8'h8B, 8'h55);
        wr(8'h88, 8'h40);
        repeat (20) @(negedge sys_clk);
        chk(ctrl_q, 8'hC0);
        wr(8'h88, 8'h80);
        pulse(1);
        rchk(8'h88, 8'h00);
        rchk(8'h8A, 8'h00);
        rchk(8'h8B, 8'h55);
        // split low byte on pin a, its own run and flag
        wr(8'h89, 8'h37);
        wr(8'h8A, 8'hFE);
        wr(8'h88, 8'h10);
        pm.count(0, 3);
        chk(ctrl_q, 8'h30);
        wr(8'h88, 8'h00);
        rchk(8'h8A, 8'h01);
        wr(8'h89, 8'h13);
        repeat (10) @(negedge sys_clk);
        rd(8'h8B, rv);
        chk_in({8'h00, rv}, 'h56, 'h70);
        // edge type: flag kept after pin rises, vectoring clears
        wr(8'h89, 8'h00);
        wr(8'h88, 8'h01);
        pm.hold(2, 1'b0);
        pm.hold(2, 1'b1);
        repeat (8) @(negedge sys_clk);
        chk(ctrl_q, 8'h03);
        pulse(2);
        rchk(8'h88, 8'h01);
        // level type: vectoring leaves the flag while the pin is low
        wr(8'h88, 8'h00);
        pm.hold(2, 1'b0);
        pulse(2);
        chk(ctrl_q, 8'h02);
        pm.hold(2, 1'b1);
        // edge type on b: flag kept after pin rises, vectoring clears
        wr(8'h88, 8'h04);
        pm.hold(3, 1'b0);
        pm.hold(3, 1'b1);
        repeat (8) @(negedge sys_clk);
        chk(ctrl_q, 8'h0C);
        pulse(3);
        rchk(8'h88, 8'h04);
        close_out();
    end
endmodule
